/* File: include/fsl_pkg.sv */
package fsl_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          NPORT      = 8;
    localparam int          PW         = 3;
    localparam int          LW         = 14;

    // ------------------------------------------------------------
    // Frame size limits in bytes
    // ------------------------------------------------------------
    localparam logic [13:0] LIM_DEF    = 14'h05DC;  // 1500
    localparam logic [13:0] LIM_FAST   = 14'h07CE;  // 1998
    localparam logic [13:0] LIM_JUMBO  = 14'h2328;  // 9000
    localparam logic [13:0] LIM_CPU    = 14'h07CE;  // 1998

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_BASE   = 8'h04;
    localparam logic [7:0]  OFS_JUMBO  = 8'h08;
    localparam logic [7:0]  OFS_ALT    = 8'h0C;
    localparam logic [7:0]  OFS_APORT  = 8'h10;
    localparam logic [7:0]  OFS_ROUTE  = 8'h14;
    localparam logic [7:0]  OFS_ABASE  = 8'h18;
    localparam logic [7:0]  OFS_AJUMBO = 8'h1C;
    localparam logic [7:0]  OFS_AALT   = 8'h20;
    localparam logic [7:0]  OFS_STAT   = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CTRL_APPLY = 0;
    localparam int          STAT_REJ   = 31;
    localparam int          STAT_JSET  = 30;

    // ------------------------------------------------------------
    // Frame kinds and drop causes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FK_SWITCH = 2'h0,
        FK_CPU    = 2'h1,
        FK_ROUTE  = 2'h2
    } fsl_kind_e;

    typedef enum logic [2:0] {
        DC_NONE   = 3'h0,
        DC_RX     = 3'h1,
        DC_EGRESS = 3'h2,
        DC_CPU    = 3'h3,
        DC_ROUTE  = 3'h4
    } fsl_cause_e;

    // Frame length check request, one per frame
    typedef struct packed {
        logic            valid;
        fsl_kind_e       kind;
        logic [PW-1:0]   in_port;
        logic [PW-1:0]   out_port;
        logic [LW-1:0]   len;
    } fsl_frm_s;

    // Verdict on one frame
    typedef struct packed {
        logic            valid;
        logic            drop;
        fsl_cause_e      cause;
    } fsl_res_s;

endpackage : fsl_pkg

/* File: verilog/fsl_filter.sv */
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps

module fsl_filter
    import fsl_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    // AHB-Lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic      [31:0]       hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    // Port speed, one bit per port, high at 1000 Mb/s
    input  wire logic [NPORT-1:0]  spd_gig_i,
    // Frame checks
    input  wire fsl_frm_s          frm_i,
    output fsl_res_s               res_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Pending copies take the writes; the in-force copies move only
    // when software asks for a switch reset through the control word
    typedef struct packed {
        logic [LW-1:0]    p_base;     // pending, waits for switch reset
        logic [LW-1:0]    p_jumbo;
        logic             p_jset;
        logic [LW-1:0]    p_alt;
        logic [NPORT-1:0] p_aport;
        logic [LW-1:0]    a_base;     // in force
        logic [LW-1:0]    a_jumbo;
        logic [LW-1:0]    a_alt;
        logic [NPORT-1:0] a_aport;
        logic [LW-1:0]    route;
        logic             route_set;
        logic             rej;
        logic             wr_pend;
        logic             rd_pend;
        logic             rd_do;
        logic [7:0]       addr;
        logic [31:0]      rdata;
        logic             ready;
        fsl_res_s         res;
    } fsl_state_s;

    fsl_state_s        st;
    fsl_state_s        next_st;

    // ------------------------------------------------------------
    // Per-port limits in force
    // ------------------------------------------------------------
    logic [LW-1:0]     jumbo_eff;
    logic [LW-1:0]     port_lim [NPORT];

    // Gigabit limit in force; the fallback to base is settled at apply
    // so a pending large-limit write cannot move it before reset
    assign jumbo_eff = st.a_jumbo;

    // Speed picks base or large limit, alternate overrides it.
    // The alternate wins even on a gigabit port, so one port can be
    // held below the switch-wide large limit
    for (genvar gp = 0; gp < NPORT; gp++) begin : g_lim
        always_comb begin
            if (st.a_aport[gp]) begin
                port_lim[gp] = st.a_alt;
            end else if (spd_gig_i[gp]) begin
                port_lim[gp] = jumbo_eff;
            end else begin
                port_lim[gp] = st.a_base;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus decode helpers
    // ------------------------------------------------------------
    logic              addr_ph;
    logic [LW-1:0]     wval;
    logic [31:0]       rd_mux;

    // Address phase is taken when selected, active and the bus ready.
    // Writes answer at once and store at the end of the data phase;
    // reads insert one wait state so the word is built from settled
    // state. Every access completes, so there is no error path.
    assign addr_ph = hsel_i & htrans_i[1] & hready_i;
    assign wval    = hwdata_i[LW-1:0];

    // ------------------------------------------------------------
    // Write value range checks
    // ------------------------------------------------------------
    // Any bit above the limit field makes a write out of range, so a
    // large value can never alias onto a legal limit
    logic              wbig;
    logic              base_clr;
    logic              base_ok;
    logic              jumbo_ok;
    logic              alt_ok;
    logic              route_ok;
    logic [LW-1:0]     alt_hi;

    assign wbig     = |hwdata_i[31:LW];
    // Zero clears the base limit back to its default
    assign base_clr = (hwdata_i == 32'h0000_0000);
    // Fast-port range for the base limit
    assign base_ok  = !wbig && wval >= LIM_DEF && wval <= LIM_FAST;
    // Gigabit range for the large limit
    assign jumbo_ok = !wbig && wval >= LIM_DEF && wval <= LIM_JUMBO;
    // Alternate sits between pending base and pending large limit,
    // falling back to base when no large limit was ever written
    assign alt_hi   = st.p_jset ? st.p_jumbo : st.p_base;
    assign alt_ok   = !wbig && wval >= st.p_base && wval <= alt_hi;
    // Routed limit is judged against the base in force, because the
    // pending base may never be applied
    assign route_ok = !wbig && wval >= LIM_DEF && wval <= st.a_base;

    // ------------------------------------------------------------
    // Alternate assignment kept at switch reset
    // ------------------------------------------------------------
    // A fast port loses an alternate above 1998; speed is judged at
    // the moment of apply, a later speed change does not revisit it
    logic [NPORT-1:0]  aport_keep;

    for (genvar ga = 0; ga < NPORT; ga++) begin : g_keep
        assign aport_keep[ga] = st.p_aport[ga] &
                                (spd_gig_i[ga] | (st.p_alt <= LIM_FAST));
    end

    // ------------------------------------------------------------
    // Frame length compares
    // ------------------------------------------------------------
    // Equal length is accepted everywhere; only longer frames drop.
    // Whole frames are judged, nothing is ever cut short
    logic              rx_over;
    logic              eg_over;
    logic              cpu_over;
    logic              rt_over;

    assign rx_over  = frm_i.len > port_lim[frm_i.in_port];
    assign eg_over  = frm_i.len > port_lim[frm_i.out_port];
    assign cpu_over = frm_i.len > LIM_CPU;
    assign rt_over  = frm_i.len > st.route;

    // Read mux; reserved bits and unmapped words read as zero.
    // In-force words show what the ports use now, pending words what
    // was written; apply loads base for a never-set large limit and
    // drops fast-port alternates above 1998
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (st.addr)
            OFS_BASE:   rd_mux[LW-1:0]    = st.p_base;
            OFS_JUMBO:  rd_mux[LW-1:0]    = st.p_jumbo;
            OFS_ALT:    rd_mux[LW-1:0]    = st.p_alt;
            OFS_APORT:  rd_mux[NPORT-1:0] = st.p_aport;
            OFS_ROUTE:  rd_mux[LW-1:0]    = st.route;
            OFS_ABASE:  rd_mux[LW-1:0]    = st.a_base;
            OFS_AJUMBO: rd_mux[LW-1:0]    = jumbo_eff;
            OFS_AALT:   rd_mux[LW-1:0]    = st.a_alt;
            OFS_STAT: begin
                rd_mux[NPORT-1:0] = st.a_aport;
                rd_mux[STAT_REJ]  = st.rej;
                rd_mux[STAT_JSET] = st.p_jset;
            end
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Reads take one wait state so that a write in the data phase
    // just before is already stored when the read word is built.
    always_comb begin
        next_st = st;

        // Bus address phase
        next_st.wr_pend = addr_ph & hwrite_i;
        next_st.rd_pend = addr_ph & ~hwrite_i;
        next_st.rd_do   = st.rd_pend;
        next_st.ready   = ~(addr_ph & ~hwrite_i);
        if (addr_ph) begin
            next_st.addr = haddr_i[7:0];
        end
        if (st.rd_pend) begin
            next_st.rdata = rd_mux;
            next_st.ready = 1'b1;
        end

        // Bus write data phase
        if (st.wr_pend) begin
            next_st.rej = 1'b0;
            unique case (st.addr)
                OFS_CTRL: begin
                    // Switch reset: pending limits go into force
                    if (hwdata_i[CTRL_APPLY]) begin
                        next_st.a_base  = st.p_base;
                        // Never-set large limit falls back to base
                        next_st.a_jumbo = st.p_jset ? st.p_jumbo :
                                                      st.p_base;
                        next_st.a_alt   = st.p_alt;
                        // Fast ports lose an alternate above 1998
                        next_st.a_aport = aport_keep;
                        if (!st.route_set || st.p_base < st.route) begin
                            next_st.route = st.p_base;
                        end
                    end
                end
                OFS_BASE: begin
                    if (base_clr) begin
                        next_st.p_base = LIM_DEF;
                    end else if (base_ok) begin
                        next_st.p_base = wval;
                    end else begin
                        next_st.rej = 1'b1;
                    end
                end
                OFS_JUMBO: begin
                    if (jumbo_ok) begin
                        next_st.p_jumbo = wval;
                        next_st.p_jset  = 1'b1;
                    end else begin
                        next_st.rej = 1'b1;
                    end
                end
                OFS_ALT: begin
                    if (alt_ok) begin
                        next_st.p_alt = wval;
                    end else begin
                        next_st.rej = 1'b1;
                    end
                end
                OFS_APORT: begin
                    next_st.p_aport = hwdata_i[NPORT-1:0];
                end
                OFS_ROUTE: begin
                    // Checked against the base in force, applied now
                    if (route_ok) begin
                        next_st.route     = wval;
                        next_st.route_set = 1'b1;
                    end else begin
                        next_st.rej = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // Frame verdict, one whole frame per request.
        // Ingress is checked first so the cause names the first limit
        next_st.res.valid = frm_i.valid;
        next_st.res.drop  = 1'b0;
        next_st.res.cause = DC_NONE;
        if (frm_i.valid) begin
            if (rx_over) begin
                next_st.res.drop  = 1'b1;
                next_st.res.cause = DC_RX;
            end else begin
                unique case (frm_i.kind)
                    FK_CPU: begin
                        if (cpu_over) begin
                            next_st.res.drop  = 1'b1;
                            next_st.res.cause = DC_CPU;
                        end
                    end
                    FK_ROUTE: begin
                        if (rt_over) begin
                            next_st.res.drop  = 1'b1;
                            next_st.res.cause = DC_ROUTE;
                        end
                    end
                    default: begin
                        if (eg_over) begin
                            next_st.res.drop  = 1'b1;
                            next_st.res.cause = DC_EGRESS;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All limits come up at 1500 after power-on reset.
    // Pending and in-force copies start equal, so nothing is waiting
    // for a switch reset until software writes a limit
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st           <= '0;
            st.p_base    <= LIM_DEF;
            st.p_jumbo   <= LIM_DEF;
            st.p_alt     <= LIM_DEF;
            st.a_base    <= LIM_DEF;
            st.a_jumbo   <= LIM_DEF;
            st.a_alt     <= LIM_DEF;
            st.route     <= LIM_DEF;
            st.ready     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answers come from the state flops; the response is tied to
    // OKAY since every access completes
    assign hrdata_o    = st.rdata;
    assign hreadyout_o = st.ready;
    assign hresp_o     = 1'b0;
    assign res_o       = st.res;

endmodule : fsl_filter

/* File: tb/fsl_properties.sv */
`timescale 1ns/100ps
module fsl_properties
    import fsl_pkg::*;
(
    // Clock and bus
    input wire logic             sys_clk_i,
    input wire logic             rst_n_i,
    input wire logic             hsel_i,
    input wire logic [1:0]       htrans_i,
    input wire logic             hwrite_i,
    input wire logic             hready_i,
    input wire logic             hreadyout_o,
    // Frames
    input wire logic [NPORT-1:0] spd_gig_i,
    input wire fsl_frm_s         frm_i,
    input wire fsl_res_s         res_o
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Steps of a read and of a frame check
    sequence rd_req;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    endsequence
    sequence rd_ans;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    sequence frm_go;
        frm_i.valid;
    endsequence

    read_wait_a: assert property (rd_req |=> rd_ans)
        else $error("read answer mistimed");
    write_fast_a: assert property
        (hsel_i && htrans_i[1] && hready_i && hwrite_i |=> hreadyout_o)
        else $error("write data phase stalled");
    res_pulse_a: assert property (frm_go |=> res_o.valid)
        else $error("verdict missing");
    res_quiet_a: assert property (!frm_i.valid |=> !res_o.valid)
        else $error("verdict without frame");
    small_pass_a: assert property
        (frm_i.valid && frm_i.len <= LIM_DEF |=> !res_o.drop
         && res_o.cause == DC_NONE) else $error("short frame dropped");
    fast_rx_a: assert property
        (frm_i.valid && !spd_gig_i[frm_i.in_port] && frm_i.len > LIM_FAST
         |=> res_o.drop && res_o.cause == DC_RX) else $error("fast rx kept");
    egress_drop_a: assert property
        (frm_i.valid && frm_i.kind == FK_SWITCH && frm_i.len > LIM_FAST
         && !spd_gig_i[frm_i.out_port] |=> res_o.drop)
        else $error("egress oversize kept");
    cpu_cap_a: assert property
        (frm_i.valid && frm_i.kind == FK_CPU && frm_i.len > LIM_CPU
         |=> res_o.drop) else $error("cpu oversize kept");
    route_cap_a: assert property
        (frm_i.valid && frm_i.kind == FK_ROUTE && frm_i.len > LIM_FAST
         |=> res_o.drop) else $error("routed oversize kept");
    giant_drop_a: assert property
        (frm_i.valid && frm_i.len > LIM_JUMBO |=> res_o.drop)
        else $error("giant frame kept");
endmodule : fsl_properties

bind fsl_filter fsl_properties u_props (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .spd_gig_i(spd_gig_i), .frm_i(frm_i),
    .res_o(res_o)
);

/* File: tb/fsl_peer.sv */
`timescale 1ns/100ps
module fsl_peer
    import fsl_pkg::*;
(
    // Clock
    input  wire logic        sys_clk_i,
    // Frame side
    input  wire fsl_res_s    res_i,
    output fsl_frm_s         frm_o,
    output logic [NPORT-1:0] spd_o
);
    // ----
    // Link peers and fabric
    // ----
    // Ports 0 and 4..7 linked at gigabit, the rest at 10/100
    initial begin
        frm_o = '0;
        spd_o = 8'hF1;
    end

    // One frame; fields scrambled after release so stale values never pass
    task automatic send(input fsl_kind_e k, input logic [PW-1:0] ip, op,
                        input logic [LW-1:0] len, output fsl_res_s r);
        @(posedge sys_clk_i);
        frm_o <= {1'b1, k, ip, op, len};
        @(posedge sys_clk_i);
        frm_o <= {1'b0, ~frm_o[21:0]};
        @(negedge sys_clk_i);
        r = res_i;
    endtask : send
endmodule : fsl_peer

/* File: tb/fsl_filter_test.sv */
`timescale 1ns/100ps
module fsl_filter_test
    import fsl_pkg::*;
;
    // ----
    // Bench
    // ----
    localparam logic [3:0] V_OK = 4'h0, V_RX = {1'b1, DC_RX};
    localparam logic [3:0] V_EG = {1'b1, DC_EGRESS}, V_CPU = {1'b1, DC_CPU};
    localparam logic [3:0] V_RT = {1'b1, DC_ROUTE};
    logic             sys_clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o;
    logic             hresp_o;
    logic [1:0]       htrans_i;
    logic [31:0]      haddr_i, hwdata_i, hrdata_o, rd;
    logic [NPORT-1:0] spd_gig_i;
    fsl_frm_s         frm_i;
    fsl_res_s         res_o, vr;
    int               errors = 0;
    int               total_checks = 0;

    fsl_filter u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .spd_gig_i(spd_gig_i),
        .frm_i(frm_i), .res_o(res_o));
    fsl_peer u_peer (.sys_clk_i(sys_clk_i), .res_i(res_o), .frm_o(frm_i),
        .spd_o(spd_gig_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic complete_run();
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Single word transfer; a read compares against d
    task automatic rw(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i  <= {24'h0, a};
        for (int p = 0; p < 2; p++) begin
            n = 0;
            @(negedge sys_clk_i);
            while (hreadyout_o !== 1'b1 && n < 20) begin
                n++;
                @(negedge sys_clk_i);
            end
            if (n == 20) begin
                errors++;
                complete_run();
            end
            rd = hrdata_o;
            @(posedge sys_clk_i);
            htrans_i <= 2'h0;
            hsel_i   <= 1'b0;
            hwdata_i <= d;
        end
        if (!w) begin
            chk(rd, d);
        end
        chk({31'h0, hresp_o}, 32'h0);
    endtask : rw

    task automatic fr(input fsl_kind_e k, input logic [2:0] ip, op,
                      input logic [13:0] len, input logic [3:0] e);
        u_peer.send(k, ip, op, len, vr);
        chk({27'h0, vr}, {27'h0, 1'b1, e});
    endtask : fr

    initial begin
        rst_n_i  <= 1'b0;
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwrite_i <= 1'b0;
        haddr_i  <= 32'h0;
        hwdata_i <= 32'h0;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // Reset state and default limits
        rw(1'b0, OFS_ROUTE, 32'h05DC);
        rw(1'b0, OFS_AJUMBO, 32'h05DC);
        rw(1'b0, 8'h40, 32'h0);
        fr(FK_SWITCH, 3'h2, 3'h3, 14'h05DD, V_RX);
        fr(FK_SWITCH, 3'h4, 3'h5, 14'h05DD, V_RX);
        // Refused settings and pending changes
        rw(1'b1, OFS_BASE, 32'h07CF);
        rw(1'b0, OFS_STAT, 32'h8000_0000);
        rw(1'b1, OFS_BASE, 32'h07CE);
        rw(1'b1, OFS_BASE, 32'h0001_0640);
        rw(1'b0, OFS_BASE, 32'h07CE);
        rw(1'b0, OFS_ABASE, 32'h05DC);
        fr(FK_SWITCH, 3'h2, 3'h3, 14'h0640, V_RX);
        rw(1'b1, OFS_ROUTE, 32'h0640);
        rw(1'b0, OFS_ROUTE, 32'h05DC);
        rw(1'b1, OFS_JUMBO, 32'h2329);
        rw(1'b1, OFS_JUMBO, 32'h1388);
        rw(1'b1, OFS_ALT, 32'h1770);
        rw(1'b0, OFS_ALT, 32'h05DC);
        rw(1'b1, OFS_ALT, 32'h0FA0);
        rw(1'b1, OFS_APORT, 32'h03);
        rw(1'b1, OFS_CTRL, 32'h1);
        rw(1'b0, OFS_AJUMBO, 32'h1388);
        rw(1'b0, OFS_AALT, 32'h0FA0);
        rw(1'b0, OFS_STAT, 32'h4000_0001);
        rw(1'b0, OFS_ROUTE, 32'h07CE);
        // Limits in force by speed, kind and assignment
        fr(FK_SWITCH, 3'h0, 3'h4, 14'h0FA0, V_OK);
        fr(FK_SWITCH, 3'h0, 3'h4, 14'h0FA1, V_RX);
        fr(FK_SWITCH, 3'h4, 3'h5, 14'h1388, V_OK);
        fr(FK_SWITCH, 3'h4, 3'h5, 14'h1389, V_RX);
        fr(FK_SWITCH, 3'h1, 3'h2, 14'h07CE, V_OK);
        fr(FK_SWITCH, 3'h2, 3'h3, 14'h07CF, V_RX);
        fr(FK_SWITCH, 3'h4, 3'h2, 14'h0BB8, V_EG);
        fr(FK_CPU, 3'h4, 3'h0, 14'h07CF, V_CPU);
        fr(FK_CPU, 3'h4, 3'h0, 14'h07CE, V_OK);
        fr(FK_ROUTE, 3'h4, 3'h5, 14'h07CE, V_OK);
        // Routed limit applies at once, apart from the alternate
        rw(1'b1, OFS_ROUTE, 32'h0640);
        fr(FK_ROUTE, 3'h4, 3'h5, 14'h0641, V_RT);
        rw(1'b1, OFS_ROUTE, 32'h05DB);
        rw(1'b1, OFS_ALT, 32'h0BB8);
        rw(1'b0, OFS_ROUTE, 32'h0640);
        // Cleared base drops routed limit at the next apply
        rw(1'b1, OFS_BASE, 32'h0);
        rw(1'b0, OFS_BASE, 32'h05DC);
        rw(1'b1, OFS_CTRL, 32'h1);
        rw(1'b0, OFS_ABASE, 32'h05DC);
        rw(1'b0, OFS_ROUTE, 32'h05DC);
        fr(FK_ROUTE, 3'h4, 3'h5, 14'h05DD, V_RT);
        // Large limit written after an apply stays pending
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rw(1'b1, OFS_BASE, 32'h07CE);
        rw(1'b1, OFS_CTRL, 32'h1);
        rw(1'b1, OFS_JUMBO, 32'h1388);
        rw(1'b0, OFS_AJUMBO, 32'h07CE);
        fr(FK_SWITCH, 3'h4, 3'h5, 14'h07CF, V_RX);
        complete_run();
    end
endmodule : fsl_filter_test
